// [touch_cfg_regs.svh]
// register offsets, field positions, reset values and timing counts
`ifndef TOUCH_CFG_REGS_SVH
`define TOUCH_CFG_REGS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define CTRL1_ADDR      8'h01
`define CFG2_ADDR       8'h02
`define CTRL1_RESET     16'h0000
`define CFG2_RESET      16'h4040
`define RDATA_NONE      16'h0000

// ****************************************************************
// fields of adc_power_filter_config
// ****************************************************************
`define PWR_HI          15
`define PWR_LO          14
`define PIN_FN_BIT      13
`define PIN_LVL_BIT     12
`define PIN_DIR_BIT     11
`define PIN_POL_BIT     10
`define SE_BIT          9
`define AVG_HI          8
`define AVG_LO          7
`define MED_HI          6
`define MED_LO          5
`define SRST_BIT        4
`define FCD_HI          3
`define FCD_LO          0

// ****************************************************************
// fields of the mode and timer register
// ****************************************************************
`define MODE_HI         11
`define MODE_LO         10
`define TMR_HI          7
`define TMR_LO          0
`define TMR_ZERO        8'h00

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS   10
`define FCD_STEP_NS     128000
`define FCD_STEP_CYCLES ((`FCD_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [touch_cfg_pkg.sv]
// types shared by the configuration block and its delay timer
package touch_cfg_pkg;

    typedef enum logic [1:0] {
        MODE_NONE,
        MODE_SINGLE,
        MODE_SLAVE,
        MODE_MASTER
    } conv_mode_type;

    typedef enum logic [1:0] {
        PWR_OFF,
        PWR_AUTO,
        PWR_ON,
        PWR_AUTO_ALT
    } power_policy_type;

    typedef enum logic {
        DLY_IDLE,
        DLY_WAIT
    } delay_state_type;

endpackage : touch_cfg_pkg

// [first_delay_timer.sv]
// first-conversion delay timer, (code + 1) steps long
`timescale 1ns/1ns
`include "touch_cfg_regs.svh"

module first_delay_timer #(
    parameter int STEP_CYCLES = `FCD_STEP_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       ce,
    input  wire logic       clear,
    input  wire logic       start,
    input  wire logic [3:0] code,
    output logic            busy_q,
    output logic            done_q
);

    touch_cfg_pkg::delay_state_type state_q;
    touch_cfg_pkg::delay_state_type state_d;
    logic [17:0] cnt_q;
    logic [17:0] cnt_d;
    logic [31:0] total;
    logic        expire;

    // a fresh start restarts the wait with the current code
    assign total   = (32'(code) + 32'h0000_0001) * 32'(STEP_CYCLES);
    assign expire  = (state_q == touch_cfg_pkg::DLY_WAIT)
                     && (cnt_q == 18'h0_0000);
    assign state_d = start  ? touch_cfg_pkg::DLY_WAIT
                   : expire ? touch_cfg_pkg::DLY_IDLE : state_q;
    assign cnt_d   = start ? 18'(total - 32'h0000_0001)
                   : (state_q == touch_cfg_pkg::DLY_WAIT && !expire)
                     ? cnt_q - 18'h0_0001 : cnt_q;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= touch_cfg_pkg::DLY_IDLE;
            cnt_q   <= 18'h0_0000;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
        end
        else if (ce)
        begin
            if (clear)
            begin
                state_q <= touch_cfg_pkg::DLY_IDLE;
                cnt_q   <= 18'h0_0000;
                busy_q  <= 1'b0;
                done_q  <= 1'b0;
            end
            else
            begin
                state_q <= state_d;
                cnt_q   <= cnt_d;
                busy_q  <= (state_d == touch_cfg_pkg::DLY_WAIT);
                done_q  <= expire && !start;
            end
        end
    end

endmodule : first_delay_timer

// [touch_adc_power_filter_config.sv]
// power, shared-pin, filter and delay configuration of the touch converter
`timescale 1ns/1ns
`include "touch_cfg_regs.svh"

module touch_adc_power_filter_config #(
    parameter int FCD_STEP_CYCLES = `FCD_STEP_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    input  wire logic        touch_pin,
    input  wire logic        shared_pin_in,
    output logic             shared_pin_out,
    output logic             shared_pin_oe,
    input  wire logic        seq_busy,
    input  wire logic        seq_done,
    input  wire logic        conv_start,
    input  wire logic        aux_req,
    input  wire logic        vbat_req,
    output logic             adc_power,
    output logic             osc_power,
    output logic             bias_power,
    output logic             temp_power,
    output logic      [1:0]  conv_mode,
    output logic      [7:0]  interval_timer,
    output logic             single_ended_select,
    output logic      [4:0]  averaging_count,
    output logic      [4:0]  median_window_count,
    output logic             measure_aux,
    output logic             measure_vbat,
    output logic             soft_logic_reset,
    output logic             first_delay_busy,
    output logic             first_delay_done
);

    // ************************************************************
    // functions
    // ************************************************************
    // pin polarity 0 means active low, so the level is inverted
    function automatic logic pin_level_f(input logic x, input logic pol);
        pin_level_f = x ^ ~pol;
    endfunction : pin_level_f

    function automatic logic [4:0] avg_count_f(input logic [1:0] avg,
                                               input logic [1:0] med);
        case (avg)
            2'h0:    avg_count_f = (med == 2'h0) ? 5'h01 : 5'h02;
            2'h1:    avg_count_f = 5'h04;
            2'h2:    avg_count_f = 5'h08;
            default: avg_count_f = 5'h10;
        endcase
    endfunction : avg_count_f

    function automatic logic [4:0] med_count_f(input logic [1:0] med);
        case (med)
            2'h0:    med_count_f = 5'h00;
            2'h1:    med_count_f = 5'h04;
            2'h2:    med_count_f = 5'h08;
            default: med_count_f = 5'h10;
        endcase
    endfunction : med_count_f

    // ************************************************************
    // registers and pin synchronisers
    // ************************************************************
    logic [15:0] cfg_q;
    logic [15:0] cfg_d;
    logic [15:0] ctrl1_q;
    logic [15:0] ctrl1_d;
    logic [1:0]  sync1_q;
    logic [1:0]  sync2_q;
    logic [1:0]  sync3_q;
    logic [1:0]  pins_q;
    logic [1:0]  pins_d;
    logic        touched;
    logic        pin_now;

    // bit 0 is the touch pin, bit 1 the shared pin
    assign pins_d  = (sync2_q & sync3_q)
                     | (pins_q & (sync2_q ^ sync3_q));
    assign touched = pins_q[0];
    assign pin_now = pins_q[1];

    // ************************************************************
    // register decode
    // ************************************************************
    logic wr_cfg;
    logic wr_ctrl1;
    logic srst_req;
    logic mode_clear;
    logic [15:0] cfg_view;
    logic [15:0] rdata_d;

    touch_cfg_pkg::conv_mode_type    mode;
    touch_cfg_pkg::power_policy_type policy;

    assign wr_cfg   = reg_wr && (reg_addr == `CFG2_ADDR);
    assign wr_ctrl1 = reg_wr && (reg_addr == `CTRL1_ADDR);
    assign srst_req = wr_cfg && reg_wdata[`SRST_BIT];
    assign mode     = touch_cfg_pkg::conv_mode_type'(
                          ctrl1_q[`MODE_HI:`MODE_LO]);
    assign policy   = touch_cfg_pkg::power_policy_type'(
                          cfg_q[`PWR_HI:`PWR_LO]);

    // single and slave runs drop back to idle when no repeat is set
    assign mode_clear = seq_done
        && (mode == touch_cfg_pkg::MODE_SINGLE
            || mode == touch_cfg_pkg::MODE_SLAVE)
        && (ctrl1_q[`TMR_HI:`TMR_LO] == `TMR_ZERO);

    // the reset bit never stays set; a software write beats the clear
    assign cfg_d   = wr_cfg ? (reg_wdata & ~(16'h0001 << `SRST_BIT))
                   : cfg_q;
    assign ctrl1_d = wr_ctrl1 ? reg_wdata
                   : mode_clear ? (ctrl1_q & ~(16'h0003 << `MODE_LO))
                   : ctrl1_q;

    // an input pin reads back its level instead of the stored data
    assign cfg_view = (cfg_q[`PIN_FN_BIT] && cfg_q[`PIN_DIR_BIT])
        ? {cfg_q[15:13], pin_level_f(pin_now, cfg_q[`PIN_POL_BIT]),
           cfg_q[11:0]}
        : cfg_q;
    assign rdata_d  = !reg_rd ? reg_rdata
                    : (reg_addr == `CFG2_ADDR)  ? cfg_view
                    : (reg_addr == `CTRL1_ADDR) ? ctrl1_q
                    : `RDATA_NONE;

    // ************************************************************
    // power, pin and channel decisions
    // ************************************************************
    logic wake;
    logic auto_pol;
    logic master;
    logic timed;
    logic adc_d;
    logic osc_d;
    logic temp_d;
    logic drive_d;
    logic aux_d;
    logic vbat_d;

    assign wake     = touched || seq_busy;
    assign auto_pol = (policy == touch_cfg_pkg::PWR_AUTO)
                      || (policy == touch_cfg_pkg::PWR_AUTO_ALT);
    assign master   = (mode == touch_cfg_pkg::MODE_MASTER);
    assign timed    = (mode == touch_cfg_pkg::MODE_SINGLE)
                      || (mode == touch_cfg_pkg::MODE_SLAVE);

    // full shutdown wins; always-on keeps sensor on demand only
    assign adc_d  = (policy == touch_cfg_pkg::PWR_ON)
                  || (auto_pol && (master ? wake : seq_busy));
    assign osc_d  = (policy == touch_cfg_pkg::PWR_ON)
                  || (auto_pol && (master ? wake : timed));
    assign temp_d = (policy != touch_cfg_pkg::PWR_OFF)
                  && ((auto_pol && master) ? wake : seq_busy);

    assign drive_d = cfg_q[`PIN_FN_BIT] && !cfg_q[`PIN_DIR_BIT];
    assign aux_d   = !cfg_q[`PIN_FN_BIT] && aux_req && !vbat_req;
    assign vbat_d  = !cfg_q[`PIN_FN_BIT] && vbat_req;

    // ************************************************************
    // state
    // ************************************************************
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_q <= 2'b00;
            sync2_q <= 2'b00;
            sync3_q <= 2'b00;
            pins_q  <= 2'b00;
        end
        else if (ce)
        begin
            sync1_q <= {shared_pin_in, touch_pin};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pins_q  <= pins_d;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg_q            <= `CFG2_RESET;
            ctrl1_q          <= `CTRL1_RESET;
            reg_rdata        <= `RDATA_NONE;
            soft_logic_reset <= 1'b0;
        end
        else if (ce)
        begin
            cfg_q            <= soft_logic_reset ? `CFG2_RESET : cfg_d;
            ctrl1_q          <= soft_logic_reset ? `CTRL1_RESET : ctrl1_d;
            reg_rdata        <= rdata_d;
            soft_logic_reset <= srst_req;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            adc_power           <= 1'b0;
            osc_power           <= 1'b0;
            bias_power          <= 1'b0;
            temp_power          <= 1'b0;
            shared_pin_out      <= 1'b0;
            shared_pin_oe       <= 1'b0;
            conv_mode           <= 2'b00;
            interval_timer      <= 8'h00;
            single_ended_select <= 1'b0;
            averaging_count     <= 5'h00;
            median_window_count <= 5'h00;
            measure_aux         <= 1'b0;
            measure_vbat        <= 1'b0;
        end
        else if (ce)
        begin
            adc_power           <= adc_d;
            osc_power           <= osc_d;
            bias_power          <= osc_d;
            temp_power          <= temp_d;
            shared_pin_out      <= pin_level_f(cfg_q[`PIN_LVL_BIT],
                                               cfg_q[`PIN_POL_BIT]);
            shared_pin_oe       <= drive_d;
            conv_mode           <= ctrl1_q[`MODE_HI:`MODE_LO];
            interval_timer      <= ctrl1_q[`TMR_HI:`TMR_LO];
            single_ended_select <= cfg_q[`SE_BIT];
            averaging_count     <= avg_count_f(cfg_q[`AVG_HI:`AVG_LO],
                                    cfg_q[`MED_HI:`MED_LO]);
            median_window_count <= med_count_f(
                                    cfg_q[`MED_HI:`MED_LO]);
            measure_aux         <= aux_d;
            measure_vbat        <= vbat_d;
        end
    end

    // ************************************************************
    // first-conversion delay
    // ************************************************************
    // the sequencer pulses conv_start ahead of the first conversion
    // and of each position or pressure channel
    first_delay_timer #(
        .STEP_CYCLES (FCD_STEP_CYCLES)
    ) u_delay (
        .clk    (clk),
        .nrst   (nrst),
        .ce     (ce),
        .clear  (soft_logic_reset),
        .start  (conv_start),
        .code   (cfg_q[`FCD_HI:`FCD_LO]),
        .busy_q (first_delay_busy),
        .done_q (first_delay_done)
    );

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    pwr_full_off_a: assert property (
        ce && policy == touch_cfg_pkg::PWR_OFF |=>
        !adc_power && !osc_power && !bias_power && !temp_power)
        else $error("analog power on during full shutdown");

    master_sleep_a: assert property (
        ce && auto_pol && master && !touched && !seq_busy |=>
        !adc_power && !osc_power && !temp_power)
        else $error("master mode powered without touch");

    timed_clock_a: assert property (
        ce && auto_pol && timed |=>
        osc_power && bias_power && (adc_power == $past(seq_busy)))
        else $error("timed mode power wrong");

    pwr_always_on_a: assert property (
        ce && policy == touch_cfg_pkg::PWR_ON |=>
        adc_power && osc_power && bias_power)
        else $error("always-on policy not powered");

    pin_drive_a: assert property (
        ce && cfg_q[`PIN_FN_BIT] && !cfg_q[`PIN_DIR_BIT] |=> shared_pin_oe
        && shared_pin_out == ($past(cfg_q[`PIN_LVL_BIT])
                              ^ ~$past(cfg_q[`PIN_POL_BIT])))
        else $error("shared pin drive wrong");

    avg_single_a: assert property (
        ce && cfg_q[`AVG_HI:`MED_LO] == 4'h0 |=>
        averaging_count == 5'h01 && median_window_count == 5'h00)
        else $error("unfiltered count not one");

    soft_reset_a: assert property (
        ce && srst_req ##1 ce |=> soft_logic_reset == 1'b0
        && cfg_q == `CFG2_RESET && ctrl1_q == `CTRL1_RESET)
        else $error("soft reset did not restore defaults");

    mode_clear_a: assert property (
        ce && mode_clear && !reg_wr |=>
        ctrl1_q[`MODE_HI:`MODE_LO] == 2'b00)
        else $error("mode not cleared after last conversion");

    channel_pick_a: assert property (
        ce && !cfg_q[`PIN_FN_BIT] && aux_req && vbat_req |=>
        measure_vbat && !measure_aux)
        else $error("battery not preferred over spare input");

    pin_ignore_a: assert property (
        ce && cfg_q[`PIN_FN_BIT] |=> !measure_aux && !measure_vbat)
        else $error("channel selected while pin in general use");

    delay_start_a: assert property (
        ce && conv_start && !soft_logic_reset |=> first_delay_busy)
        else $error("first delay did not start");

endmodule : touch_adc_power_filter_config

// [screen_model.sv]
// touch screen and outside source of the shared pin
`timescale 1ns/1ns

module screen_model (
    input  wire logic touch_cmd,
    input  wire logic level_cmd,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output logic      touch_pin,
    output logic      pin_in
);
    // one wire: the converter's drive wins while enabled, otherwise the
    // outside source sets the level, so a stale drive never lingers
    assign touch_pin = touch_cmd;
    assign pin_in    = pin_oe ? pin_out : level_cmd;
endmodule : screen_model

// [testbench.sv]
// self-checking bench of the touch converter configuration block
`timescale 1ns/1ns
`include "touch_cfg_regs.svh"

module testbench;
    localparam int STEP = 4;
    logic        clk       = 1'b0;
    logic        ce        = 1'b1;
    logic        nrst      = 1'b0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        seq_busy  = 1'b0;
    logic        seq_done  = 1'b0;
    logic        conv_start = 1'b0;
    logic        aux_req   = 1'b0;
    logic        vbat_req  = 1'b0;
    logic        touch_cmd = 1'b0;
    logic        level_cmd = 1'b0;
    logic        touch_pin;
    logic        pin_in;
    logic [15:0] reg_rdata;
    logic        pin_out;
    logic        pin_oe;
    logic        adc_p;
    logic        osc_p;
    logic        bias_p;
    logic        temp_p;
    logic [1:0]  conv_mode;
    logic [7:0]  interval_timer;
    logic        se_sel;
    logic [4:0]  avg_cnt;
    logic [4:0]  med_cnt;
    logic        m_aux;
    logic        m_vbat;
    logic        soft_rst;
    logic        dly_busy;
    logic        dly_done;
    int          n_fail = 0;
    int          checks = 0;
    int          n_soft = 0;
    int          n;

    always #5 clk = ~clk;

    always @(posedge clk)
        if (soft_rst === 1'b1)
            n_soft++;

    touch_adc_power_filter_config #(.FCD_STEP_CYCLES(STEP))
    i_touch_adc_power_filter_config (
        .clk(clk), .nrst(nrst), .ce(ce),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .touch_pin(touch_pin), .shared_pin_in(pin_in),
        .shared_pin_out(pin_out), .shared_pin_oe(pin_oe),
        .seq_busy(seq_busy), .seq_done(seq_done), .conv_start(conv_start),
        .aux_req(aux_req), .vbat_req(vbat_req),
        .adc_power(adc_p), .osc_power(osc_p), .bias_power(bias_p),
        .temp_power(temp_p), .conv_mode(conv_mode),
        .interval_timer(interval_timer), .single_ended_select(se_sel),
        .averaging_count(avg_cnt), .median_window_count(med_cnt),
        .measure_aux(m_aux), .measure_vbat(m_vbat),
        .soft_logic_reset(soft_rst), .first_delay_busy(dly_busy),
        .first_delay_done(dly_done)
    );

    screen_model i_screen_model (
        .touch_cmd(touch_cmd), .level_cmd(level_cmd), .pin_out(pin_out),
        .pin_oe(pin_oe), .touch_pin(touch_pin), .pin_in(pin_in)
    );

    // ****************************************************************
    // access tasks
    // ****************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // derived outputs settle two edges after the write; wait three
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        repeat (3) @(negedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(negedge clk);
        reg_rd   = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        chk(reg_rdata, exp);
    endtask : rd

    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : pulse

    task automatic results;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    // expected {adc, osc, bias, temp}
    function automatic logic [3:0] pwr(input int pm, md, b, t);
        if (pm == 0)
            return 4'h0;
        if (pm == 2)
            return {3'b111, b[0]};
        if (md == 3)
            return {4{b[0] | t[0]}};
        return {b[0], md != 0, md != 0, b[0]};
    endfunction : pwr

    // ****************************************************************
    // tests
    // ****************************************************************
    initial
    begin
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        rd(`CFG2_ADDR, `CFG2_RESET);
        rd(`CTRL1_ADDR, `CTRL1_RESET);
        wr(8'h03, 16'hFFFF);
        rd(8'h03, `RDATA_NONE);
        $display("test registers done");
        for (int pm = 0; pm < 4; pm++)
            for (int md = 0; md < 4; md++)
                for (int b = 0; b < 2; b++)
                begin
                    seq_busy = b[0];
                    wr(`CTRL1_ADDR, 16'(md << 10));
                    wr(`CFG2_ADDR, 16'(pm << 14) | 16'h0040);
                    chk(16'(conv_mode), 16'(md));
                    chk(16'({adc_p, osc_p, bias_p, temp_p}),
                        16'(pwr(pm, md, b, 0)));
                end
        seq_busy  = 1'b0;
        touch_cmd = 1'b1;
        repeat (6) @(negedge clk);
        chk(16'({adc_p, osc_p, bias_p, temp_p}), 16'h000F);
        touch_cmd = 1'b0;
        $display("test power done");
        for (int av = 0; av < 4; av++)
            for (int md = 0; md < 4; md++)
            begin
                wr(`CFG2_ADDR, 16'((av << 7) | (md << 5) | ((av & 1) << 9)));
                chk(16'(avg_cnt),
                    (av | md) == 0 ? 16'h0001 : 16'(1 << (av + 1)));
                chk(16'(med_cnt),
                    md == 0 ? 16'h0000 : 16'(1 << (md + 1)));
                chk(16'(se_sel), 16'(av & 1));
            end
        $display("test filters done");
        for (int k = 0; k < 4; k++)
        begin
            wr(`CFG2_ADDR, {3'b001, k[1], 1'b0, k[0], 10'h000});
            chk(16'({pin_oe, pin_out}), 16'({1'b1, k[1] ^ ~k[0]}));
            level_cmd = k[1];
            wr(`CFG2_ADDR, {5'b00101, k[0], 10'h000});
            repeat (6) @(negedge clk);
            chk(16'(pin_oe), 16'h0000);
            rd(`CFG2_ADDR,
               {3'b001, k[1] ^ ~k[0], 1'b1, k[0], 10'h000});
        end
        aux_req  = 1'b1;
        vbat_req = 1'b1;
        wr(`CFG2_ADDR, 16'h2000);
        chk(16'({m_aux, m_vbat}), 16'h0000);
        wr(`CFG2_ADDR, 16'h0000);
        chk(16'({m_aux, m_vbat}), 16'h0001);
        vbat_req = 1'b0;
        repeat (3) @(negedge clk);
        chk(16'({m_aux, m_vbat}), 16'h0002);
        $display("test shared pin done");
        wr(`CTRL1_ADDR, 16'h0400);
        pulse(seq_done);
        repeat (3) @(negedge clk);
        chk(16'(conv_mode), 16'h0000);
        rd(`CTRL1_ADDR, 16'h0000);
        wr(`CTRL1_ADDR, 16'h0805);
        pulse(seq_done);
        repeat (3) @(negedge clk);
        chk(16'(conv_mode), 16'h0002);
        chk(16'(interval_timer), 16'h0005);
        $display("test mode clear done");
        for (int c = 0; c < 16; c += 15)
        begin
            wr(`CFG2_ADDR, 16'(c));
            n = 0;
            pulse(conv_start);
            chk(16'(dly_busy), 16'h0001);
            while (dly_done !== 1'b1 && n < 200)
            begin
                @(negedge clk);
                n++;
            end
            chk(16'(n), 16'((c + 1) * STEP));
            chk(16'({dly_busy, dly_done}), 16'h0001);
        end
        $display("test first delay done");
        n_soft = 0;
        wr(`CFG2_ADDR, 16'h8010);
        chk(16'(n_soft), 16'h0001);
        rd(`CFG2_ADDR, `CFG2_RESET);
        rd(`CTRL1_ADDR, `CTRL1_RESET);
        $display("test soft reset done");
        ce = 1'b0;
        wr(`CFG2_ADDR, 16'h8000);
        ce = 1'b1;
        rd(`CFG2_ADDR, `CFG2_RESET);
        chk(16'({adc_p, osc_p, bias_p}), 16'h0000);
        $display("test clock enable done");
        results();
    end

    // the whole sequence needs well under 3000 cycles
    initial
    begin
        #200000;
        n_fail++;
        results();
    end
endmodule : testbench
